// [hdl/blfr_top.sv]
// Two-wire register slave with fault and thermal reporting
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "blfr_cfg.svh"
module blfr_top import blfr_pkg::*; #(
    parameter logic [6:0] SLAVE_ADDR = `BLFR_SLAVE_ADDR,
    // Arbitrary identity value
    parameter logic [7:0] ID_VALUE = 8'h5a,
    parameter int SYNC_STAGES = 2
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA,
    output logic O_SDA_OE_N,
    input wire logic I_EN,
    input wire logic [2:0] I_VIN_BELOW,
    input wire logic I_OCP_DET,
    input wire logic [`BLFR_TEMP_W-1:0] I_TEMP,
    output logic O_FAULT,
    output logic O_FAULT_OE_N,
    output logic O_SHUTDOWN,
    output logic [7:0] O_PWM_REDUCE,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [`BLFR_APB_AW-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR
);
    blfr_pin_if #(.W(`BLFR_SYNC_W)) pins();

    logic scl;
    logic sda;
    logic en;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    blfr_state_t state;
    blfr_phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic wr_stb;
    logic [7:0] wr_data;
    logic load_now;
    logic [7:0] load_addr;
    logic [7:0] load_val;
    logic [7:0] brt;
    logic [7:0] ctrl;
    logic [7:0] direct;
    logic [2:0] temp_lsb;
    logic [7:0] fault;
    logic [7:0] next_fault;
    logic [7:0] fault_set;
    logic fault_clr;
    logic [1:0] uv_sel;
    logic [1:0] tl_sel;
    logic uv_active;
    logic tsd_active;
    logic regulating;
    logic [7:0] temp_deg;
    logic [7:0] temp_lim;
    logic [7:0] excess;
    logic [7:0] next_reduce;
    logic [31:0] status_word;
    logic apb_access;

    assign pins.raw = {I_OCP_DET, I_VIN_BELOW, I_EN, I_SDA, I_SCL};

    blfr_sync #(
        .W(`BLFR_SYNC_W),
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .p(pins.syncer)
    );

    assign scl = pins.synced[`BLFR_SY_SCL];
    assign sda = pins.synced[`BLFR_SY_SDA];
    assign en = pins.synced[`BLFR_SY_EN];

    // Register readback shared by first load and burst reload
    function automatic logic [7:0] reg_value(input logic [7:0] a);
        case (a)
            `BLFR_REG_BRT: reg_value = brt;
            `BLFR_REG_CTRL: reg_value = ctrl;
            `BLFR_REG_FAULT: reg_value = fault;
            `BLFR_REG_ID: reg_value = ID_VALUE;
            `BLFR_REG_DIRECT: reg_value = direct;
            `BLFR_REG_TEMP_MSB: begin
                reg_value = I_TEMP[`BLFR_TEMP_W-1:`BLFR_TEMP_INT_LSB];
            end
            `BLFR_REG_TEMP_LSB: reg_value = {5'h00, temp_lsb};
            default: reg_value = `BLFR_RST_BYTE;
        endcase
    endfunction

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    assign scl_rise = scl & ~scl_d;
    assign scl_fall = ~scl & scl_d;
    assign start_c = scl & scl_d & sda_d & ~sda;
    assign stop_c = scl & scl_d & ~sda_d & sda;

    assign load_now = scl_fall & (((state == BLFR_ST_RXACK) &
                      (phase == BLFR_PH_ADDR) & rw) |
                      ((state == BLFR_ST_TXACK) & ~nack));
    assign load_addr = (state == BLFR_ST_TXACK) ? 8'(ptr + 8'h01) : ptr;
    assign load_val = reg_value(load_addr);

    // Serial engine; bus lines are never driven high
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state <= BLFR_ST_IDLE;
            phase <= BLFR_PH_ADDR;
            bit_cnt <= 4'h0;
            rx_shift <= `BLFR_RST_BYTE;
            tx_shift <= `BLFR_RST_BYTE;
            rw <= 1'b0;
            nack <= 1'b1;
            ptr <= `BLFR_RST_BYTE;
            wr_stb <= 1'b0;
            wr_data <= `BLFR_RST_BYTE;
            O_SDA_OE_N <= 1'b1;
        end else begin
            wr_stb <= 1'b0;
            if (start_c) begin
                state <= BLFR_ST_RX;
                phase <= BLFR_PH_ADDR;
                bit_cnt <= 4'h0;
                O_SDA_OE_N <= 1'b1;
            end else if (stop_c) begin
                state <= BLFR_ST_IDLE;
                O_SDA_OE_N <= 1'b1;
            end else if (scl_rise) begin
                if (state == BLFR_ST_RX) begin
                    rx_shift <= {rx_shift[6:0], sda};
                    bit_cnt <= 4'(bit_cnt + 4'h1);
                end
                if (state == BLFR_ST_TXACK) begin
                    nack <= sda;
                end
            end else if (scl_fall) begin
                case (state)
                    BLFR_ST_RX: begin
                        if (bit_cnt == `BLFR_BYTE_BITS) begin
                            bit_cnt <= 4'h0;
                            state <= BLFR_ST_RXACK;
                            O_SDA_OE_N <= 1'b0;
                            case (phase)
                                BLFR_PH_ADDR: begin
                                    if (rx_shift[7:1] != SLAVE_ADDR) begin
                                        state <= BLFR_ST_IDLE;
                                        O_SDA_OE_N <= 1'b1;
                                    end
                                    rw <= rx_shift[0];
                                end
                                BLFR_PH_PTR: begin
                                    ptr <= rx_shift;
                                end
                                default: begin
                                    wr_stb <= 1'b1;
                                    wr_data <= rx_shift;
                                end
                            endcase
                        end
                    end
                    BLFR_ST_RXACK: begin
                        O_SDA_OE_N <= 1'b1;
                        if (load_now) begin
                            state <= BLFR_ST_TX;
                            tx_shift <= load_val;
                            // release for ones, low for zeros
                            O_SDA_OE_N <= load_val[7];
                            bit_cnt <= 4'h0;
                        end else begin
                            state <= BLFR_ST_RX;
                            if (phase == BLFR_PH_DATA) begin
                                ptr <= 8'(ptr + 8'h01);
                            end
                            if (phase == BLFR_PH_ADDR) begin
                                phase <= BLFR_PH_PTR;
                            end else begin
                                phase <= BLFR_PH_DATA;
                            end
                        end
                    end
                    BLFR_ST_TX: begin
                        if (bit_cnt == `BLFR_LAST_TX_BIT) begin
                            state <= BLFR_ST_TXACK;
                            O_SDA_OE_N <= 1'b1;
                        end else begin
                            bit_cnt <= 4'(bit_cnt + 4'h1);
                            tx_shift <= {tx_shift[6:0], 1'b0};
                            O_SDA_OE_N <= tx_shift[6];
                        end
                    end
                    BLFR_ST_TXACK: begin
                        if (load_now) begin
                            ptr <= load_addr;
                            tx_shift <= load_val;
                            O_SDA_OE_N <= load_val[7];
                            bit_cnt <= 4'h0;
                            state <= BLFR_ST_TX;
                        end else begin
                            state <= BLFR_ST_IDLE;
                        end
                    end
                    default: begin
                        state <= BLFR_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Writable registers behind the serial pointer
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            brt <= `BLFR_RST_BYTE;
            ctrl <= `BLFR_RST_BYTE;
            direct <= `BLFR_RST_BYTE;
        end else if (wr_stb) begin
            case (ptr)
                `BLFR_REG_BRT: brt <= wr_data;
                `BLFR_REG_CTRL: ctrl <= wr_data & `BLFR_CTRL_MASK;
                `BLFR_REG_DIRECT: direct <= wr_data & `BLFR_DIRECT_MASK;
                default: brt <= brt;
            endcase
        end
    end

    // freeze low bits with the high byte
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            temp_lsb <= 3'h0;
        end else if (load_now && load_addr == `BLFR_REG_TEMP_MSB) begin
            temp_lsb <= I_TEMP[`BLFR_TEMP_FRAC_MSB:0];
        end
    end

    always_comb begin
        case (uv_sel)
            2'h1: uv_active = pins.synced[`BLFR_SY_VIN_LSB];
            2'h2: uv_active = pins.synced[`BLFR_SY_VIN_LSB + 1];
            2'h3: uv_active = pins.synced[`BLFR_SY_VIN_MSB];
            default: uv_active = 1'b0;
        endcase
    end

    assign temp_deg = I_TEMP[`BLFR_TEMP_INT_MSB:`BLFR_TEMP_INT_LSB];

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            tsd_active <= 1'b0;
        end else if (temp_deg >= `BLFR_TSD_ON_C) begin
            tsd_active <= 1'b1;
        end else if (temp_deg < `BLFR_TSD_OFF_C) begin
            tsd_active <= 1'b0;
        end
    end

    // Regulation events stay out of this vector
    always_comb begin
        fault_set = `BLFR_RST_BYTE;
        fault_set[`BLFR_FLT_UV] = uv_active;
        fault_set[`BLFR_FLT_TSD] = tsd_active;
        fault_set[`BLFR_FLT_OCP] = pins.synced[`BLFR_SY_OCP];
    end

    // read of fault register or enable low
    assign fault_clr = ~en |
                       (load_now && load_addr == `BLFR_REG_FAULT);
    // Set wins so an event in the clearing cycle survives
    assign next_fault = (fault & ~{8{fault_clr}}) | fault_set;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            fault <= `BLFR_RST_BYTE;
            O_FAULT_OE_N <= 1'b1;
            O_FAULT <= 1'b0;
            O_SDA <= 1'b0;
        end else begin
            fault <= next_fault;
            O_FAULT_OE_N <= ~(|next_fault);
            O_FAULT <= 1'b0;
            O_SDA <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_SHUTDOWN <= 1'b0;
        end else begin
            O_SHUTDOWN <= uv_active | tsd_active | fault[`BLFR_FLT_OCP];
        end
    end

    always_comb begin
        case (tl_sel)
            2'h1: temp_lim = `BLFR_TLIM_1_C;
            2'h2: temp_lim = `BLFR_TLIM_2_C;
            2'h3: temp_lim = `BLFR_TLIM_3_C;
            default: temp_lim = `BLFR_TLIM_3_C;
        endcase
        regulating = en & (tl_sel != 2'h0) & (temp_deg > temp_lim);
        excess = regulating ? 8'(temp_deg - temp_lim) : 8'h00;
        // Saturate at full scale rather than wrap
        if (excess >= `BLFR_PWM_SAT_C) begin
            next_reduce = `BLFR_PWM_FULL;
        end else begin
            next_reduce = 8'(excess * `BLFR_PWM_STEP);
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PWM_REDUCE <= 8'h00;
        end else begin
            O_PWM_REDUCE <= next_reduce;
        end
    end

    // Software view of live status
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[0] = O_SHUTDOWN;
        status_word[1] = uv_active;
        status_word[2] = tsd_active;
        status_word[3] = regulating;
        status_word[4] = (state != BLFR_ST_IDLE);
        status_word[`BLFR_ST_REDUCE_MSB:`BLFR_ST_REDUCE_LSB] =
            O_PWM_REDUCE;
        status_word[`BLFR_ST_FAULT_MSB:`BLFR_ST_FAULT_LSB] = fault;
    end

    assign apb_access = I_PSEL & I_PENABLE;

    // One wait state; data is ready with pready
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY <= apb_access & ~O_PREADY;
            O_PSLVERR <= 1'b0;
            if (apb_access && !O_PREADY) begin
                case (I_PADDR)
                    `BLFR_APB_CFG: begin
                        O_PRDATA <= {28'h000_0000, tl_sel, uv_sel};
                    end
                    `BLFR_APB_STATUS: O_PRDATA <= status_word;
                    default: begin
                        O_PRDATA <= 32'h0000_0000;
                        O_PSLVERR <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Write lands on the completing edge only
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            uv_sel <= 2'h0;
            tl_sel <= 2'h0;
        end else if (apb_access && O_PREADY && I_PWRITE &&
                     I_PADDR == `BLFR_APB_CFG) begin
            uv_sel <= I_PWDATA[`BLFR_CFG_UV_MSB:`BLFR_CFG_UV_LSB];
            tl_sel <= I_PWDATA[`BLFR_CFG_TL_MSB:`BLFR_CFG_TL_LSB];
        end
    end
endmodule

// [hdl/blfr_cfg.svh]
// Constants for the backlight fault and two-wire slave block
`ifndef BLFR_CFG_SVH
`define BLFR_CFG_SVH

`define BLFR_SLAVE_ADDR 7'h2c
`define BLFR_REG_BRT 8'h00
`define BLFR_REG_CTRL 8'h01
`define BLFR_REG_FAULT 8'h02
`define BLFR_REG_ID 8'h03
`define BLFR_REG_DIRECT 8'h04
`define BLFR_REG_TEMP_MSB 8'h05
`define BLFR_REG_TEMP_LSB 8'h06
`define BLFR_CTRL_MASK 8'h07
`define BLFR_DIRECT_MASK 8'h0f
`define BLFR_RST_BYTE 8'h00
`define BLFR_FLT_UV 0
`define BLFR_FLT_TSD 1
`define BLFR_FLT_OCP 2
`define BLFR_BYTE_BITS 4'h8
`define BLFR_LAST_TX_BIT 4'h7
`define BLFR_TEMP_W 11
`define BLFR_TEMP_INT_MSB 10
`define BLFR_TEMP_INT_LSB 3
`define BLFR_TEMP_FRAC_MSB 2
`define BLFR_TSD_ON_C 8'h96
`define BLFR_TSD_OFF_C 8'h82
`define BLFR_TLIM_1_C 8'h6e
`define BLFR_TLIM_2_C 8'h78
`define BLFR_TLIM_3_C 8'h82
`define BLFR_PWM_STEP 8'h02
`define BLFR_PWM_FULL 8'h64
`define BLFR_PWM_SAT_C 8'h32
`define BLFR_SYNC_W 7
`define BLFR_SY_SCL 0
`define BLFR_SY_SDA 1
`define BLFR_SY_EN 2
`define BLFR_SY_VIN_LSB 3
`define BLFR_SY_VIN_MSB 5
`define BLFR_SY_OCP 6
`define BLFR_APB_AW 12
`define BLFR_APB_CFG 12'h000
`define BLFR_APB_STATUS 12'h004
`define BLFR_CFG_UV_LSB 0
`define BLFR_CFG_UV_MSB 1
`define BLFR_CFG_TL_LSB 2
`define BLFR_CFG_TL_MSB 3
`define BLFR_ST_REDUCE_LSB 8
`define BLFR_ST_REDUCE_MSB 15
`define BLFR_ST_FAULT_LSB 16
`define BLFR_ST_FAULT_MSB 23

`endif

// [hdl/blfr_pkg.sv]
// Types shared by the backlight fault and two-wire slave block
package blfr_pkg;

    typedef enum logic [2:0] {
        BLFR_ST_IDLE = 3'h0,
        BLFR_ST_RX = 3'h1,
        BLFR_ST_RXACK = 3'h3,
        BLFR_ST_TX = 3'h2,
        BLFR_ST_TXACK = 3'h6
    } blfr_state_t;

    typedef enum logic [1:0] {
        BLFR_PH_ADDR = 2'h0,
        BLFR_PH_PTR = 2'h1,
        BLFR_PH_DATA = 2'h3
    } blfr_phase_t;

endpackage

// [hdl/blfr_pin_if.sv]
// Raw and synchronised external inputs
`timescale 1ns/1ps
`include "blfr_cfg.svh"
interface blfr_pin_if #(
    parameter int W = `BLFR_SYNC_W
);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport syncer(input raw, output synced);
    modport core(output raw, input synced);
endinterface

// [hdl/blfr_sync.sv]
// Multi-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
module blfr_sync #(
    parameter int W = 7,
    parameter int STAGES = 2
) (
    input wire logic i_clk,
    input wire logic i_rst,
    blfr_pin_if.syncer p
);
    logic [W-1:0] stg [STAGES];

    if (STAGES < 2) begin : g_chk
        $error("blfr_sync needs at least two stages");
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stg[0] <= '0;
        end else begin
            stg[0] <= p.raw;
        end
    end

    // First stage feeds only the next stage
    for (genvar i = 1; i < STAGES; i++) begin : g_stg
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                stg[i] <= '0;
            end else begin
                stg[i] <= stg[i-1];
            end
        end
    end

    assign p.synced = stg[STAGES-1];
endmodule

// [bench/blfr_chk.sv]
// Pin-level checker for the two-wire and fault block
`timescale 1ns/1ps
module blfr_chk (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic O_SDA,
    input wire logic O_SDA_OE_N,
    input wire logic I_EN,
    input wire logic [2:0] I_VIN_BELOW,
    input wire logic I_OCP_DET,
    input wire logic [10:0] I_TEMP,
    input wire logic O_FAULT,
    input wire logic O_FAULT_OE_N,
    input wire logic O_SHUTDOWN,
    input wire logic [7:0] O_PWM_REDUCE
);
    logic cause;
    logic [3:0] quiet;
    logic [3:0] en_low;
    // Hysteresis band counts as a cause, so no false alarms
    assign cause = I_OCP_DET | (|I_VIN_BELOW) | (I_TEMP[10:3] >= 8'h82);
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST || cause) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
        end
    end
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST || I_EN) begin
            en_low <= 4'h0;
        end else if (en_low != 4'hf) begin
            en_low <= en_low + 4'h1;
        end
    end
    default clocking dc @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    sequence start_cond;
        I_SCL && $fell(I_SDA);
    endsequence
    sequence shut_fault;
        O_SHUTDOWN && !O_FAULT_OE_N;
    endsequence
    pin_low_only_a:
        assert property (!O_SDA && !O_FAULT)
        else $error("pin driven high");
    drive_scl_low_a:
        assert property ($changed(O_SDA_OE_N) |-> !I_SCL)
        else $error("data moved with clock high");
    start_release_a:
        assert property (start_cond |-> O_SDA_OE_N [*4])
        else $error("data held across start");
    ocp_shut_a:
        assert property ($rose(I_OCP_DET) |-> ##[1:6] shut_fault)
        else $error("no over-current shutdown");
    tsd_shut_a:
        assert property (I_TEMP[10:3] >= 8'h96 |-> ##[1:6] shut_fault)
        else $error("no thermal shutdown");
    pwm_step_a:
        assert property (O_PWM_REDUCE <= 8'h64 && !O_PWM_REDUCE[0])
        else $error("bad reduction step");
    reg_no_fault_a:
        assert property ($fell(O_FAULT_OE_N) |-> quiet < 4'h8)
        else $error("fault without cause");
    en_clear_a:
        assert property (en_low > 4'h5 && quiet > 4'h7
            |-> O_FAULT_OE_N && !O_SHUTDOWN)
        else $error("faults kept with enable low");
endmodule
bind blfr_top blfr_chk blfr_chk_i (
    .I_CLK, .I_RST, .I_SCL, .I_SDA, .O_SDA, .O_SDA_OE_N, .I_EN,
    .I_VIN_BELOW, .I_OCP_DET, .I_TEMP, .O_FAULT, .O_FAULT_OE_N,
    .O_SHUTDOWN, .O_PWM_REDUCE
);

// [bench/blfr_master.sv]
// Behavioural two-wire bus master
`timescale 1ns/1ps
module blfr_master (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_pull
);
    // Quarter of the 125 ns bus clock period
    localparam realtime Q = 31.25;
    initial begin
        o_scl = 1'b1;
        o_pull = 1'b0;
    end
    task automatic start();
        if (o_scl) begin
            @(posedge i_clk);
            #3;
        end
        o_pull = 1'b0;
        #Q o_scl = 1'b1;
        #Q o_pull = 1'b1;
        #Q o_scl = 1'b0;
        #Q;
    endtask
    // MSB first; slot released; nack by tx[0]
    task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            // data moves only with clock low
            o_pull = ~tx[i];
            #Q o_scl = 1'b1;
            #Q rx[i] = i_sda;
            #Q o_scl = 1'b0;
            #Q;
        end
    endtask
    task automatic stop();
        o_pull = 1'b1;
        #Q o_scl = 1'b1;
        #Q o_pull = 1'b0;
        #(2 * Q);
        @(posedge i_clk);
    endtask
endmodule

// [bench/blfr_top_tb.sv]
// Self-checking bench for the two-wire and fault block
`timescale 1ns/1ps
module blfr_top_tb;
    // Arbitrary identity value
    localparam logic [7:0] ID = 8'h3c;
    localparam logic [23:0] ROWS [6] = '{24'h00a5a5, 24'h01ff07,
        24'h04ff0f, 24'h02ff00, {16'h0300, ID}, 24'h073300};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b1;
    logic ocp = 1'b0;
    logic [2:0] vin = 3'h0;
    logic [10:0] temp = 11'h0c8;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic scl, pull, o_sda, oe_n, sda, perr, fault, fault_oe_n, shut;
    logic pready, pslverr;
    logic [31:0] prdata, q;
    logic [7:0] red;
    logic [8:0] rx;
    logic [7:0] rd [3];
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    assign sda = (oe_n | o_sda) & ~pull;
    always #5 clk = ~clk;
    blfr_top #(.ID_VALUE(ID)) blfr_top_i (.I_CLK(clk), .I_RST(rst),
        .I_SCL(scl), .I_SDA(sda), .O_SDA(o_sda), .O_SDA_OE_N(oe_n),
        .I_EN(en), .I_VIN_BELOW(vin), .I_OCP_DET(ocp), .I_TEMP(temp),
        .O_FAULT(fault), .O_FAULT_OE_N(fault_oe_n), .O_SHUTDOWN(shut),
        .O_PWM_REDUCE(red), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));
    blfr_master blfr_master_i (.i_clk(clk), .i_sda(sda), .o_scl(scl),
        .o_pull(pull));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wb(input logic [7:0] b);
        blfr_master_i.bits({b, 1'b1}, rx);
        chk(rx[0], 1'b0);
    endtask
    task automatic iw(input logic [7:0] p, d0, d1, input int n);
        blfr_master_i.start();
        wb(8'h58);
        wb(p);
        wb(d0);
        if (n > 1) wb(d1);
        blfr_master_i.stop();
    endtask
    task automatic ir(input logic [7:0] p, input int n);
        blfr_master_i.start();
        wb(8'h58);
        wb(p);
        blfr_master_i.start();
        wb(8'h59);
        for (int i = 0; i < n; i++) begin
            blfr_master_i.bits({8'hff, i == n - 1}, rx);
            rd[i] = rx[8:1];
        end
        blfr_master_i.stop();
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Ceiling about seven times the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        int lim;
        w(2);
        rst <= 1'b0;
        w(4);
        chk({oe_n, fault_oe_n, shut, red}, 11'h600);
        apb(1'b0, 12'h000, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(perr, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            iw(ROWS[i][23:16], ROWS[i][15:8], 8'h00, 1);
            ir(ROWS[i][23:16], 1);
            chk(rd[0], ROWS[i][7:0]);
        end
        iw(8'h00, 8'h11, 8'h26, 2);
        ir(8'h00, 3);
        chk({rd[0], rd[1], rd[2]}, 24'h110600);
        blfr_master_i.start();
        blfr_master_i.bits({8'h5a, 1'b1}, rx);
        blfr_master_i.stop();
        chk(rx[0], 1'b1);
        temp <= {8'h64, 3'h5};
        ir(8'h05, 2);
        chk({rd[0], rd[1]}, 16'h6405);
        temp <= {8'h65, 3'h2};
        ir(8'h06, 1);
        chk(rd[0], 8'h05);
        $display("test serial done");
        temp <= {8'h7d, 3'h0};
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, 12'h000, 32'(s << 2));
            w(4);
            lim = 100 + 10 * s;
            chk(red, (s == 0 || lim >= 125) ? 0 : 2 * (125 - lim));
            chk(fault_oe_n, 1'b1);
        end
        temp <= 11'h0c8;
        for (int s = 0; s < 4; s++) begin
            vin <= 3'h6;
            apb(1'b1, 12'h000, 32'(s));
            w(6);
            chk({shut, fault_oe_n}, {s > 1, s < 2});
            vin <= 3'h0;
            w(6);
            chk({shut, fault_oe_n}, {1'b0, s < 2});
            en <= 1'b0;
            w(8);
            en <= 1'b1;
            w(6);
            chk(fault_oe_n, 1'b1);
        end
        $display("test thresholds done");
        ocp <= 1'b1;
        w(5);
        ocp <= 1'b0;
        w(6);
        chk({shut, fault_oe_n}, 2'b10);
        apb(1'b0, 12'h004, 32'h0);
        chk({q[23:16], q[0]}, 9'h009);
        ir(8'h02, 1);
        w(2);
        chk({rd[0], shut, fault_oe_n}, 10'h011);
        temp <= {8'h96, 3'h0};
        w(6);
        chk({shut, fault_oe_n}, 2'b10);
        temp <= {8'h8c, 3'h0};
        w(6);
        chk(shut, 1'b1);
        temp <= {8'h81, 3'h7};
        w(6);
        chk(shut, 1'b0);
        ir(8'h02, 1);
        chk(rd[0], 8'h02);
        $display("test faults done");
        close_out();
    end
endmodule
